// ---- inc/ufl_map.svh ----
// Register map, field positions and reset values of the buffer and line
// control block. Assumes an APB host port with 32-bit data and byte offsets.
`ifndef UFL_MAP_SVH
`define UFL_MAP_SVH
`define UFL_ADDR_W        8
`define UFL_OFS_IDENT     8'h08
`define UFL_OFS_BUF_CTRL  8'h08
`define UFL_OFS_LINE_CTRL 8'h0c
`define UFL_BC_RX_THR_HI  7
`define UFL_BC_RX_THR_LO  6
`define UFL_BC_TX_THR_HI  5
`define UFL_BC_TX_THR_LO  4
`define UFL_BC_DMA_MODE   3
`define UFL_BC_TX_RESET   2
`define UFL_BC_RX_RESET   1
`define UFL_BC_BUF_EN     0
`define UFL_LC_DIV_WIN    7
`define UFL_LC_BREAK      6
`define UFL_LC_EVEN       4
`define UFL_LC_CHECK_ON   3
`define UFL_LC_STOP       2
`define UFL_LC_WIDTH_HI   1
`define UFL_LC_WIDTH_LO   0
`define UFL_LC_WMASK      8'hdf
`define UFL_RESET_BC      8'h00
`define UFL_RESET_LC      8'h00
`define UFL_DEPTH         7'h40
`define UFL_LVL_W         7
`define UFL_IR_DIV        8'h10
`endif

// ---- inc/ufl_pkg.sv ----
// Types shared by the buffer and line control block.
// Assumes the map header supplies every register number; the break state codes are set here.
package ufl_pkg;
  typedef enum logic [2:0] {
    UFL_BRK_IDLE = 3'b001,
    UFL_BRK_LINE = 3'b010,
    UFL_BRK_LOOP = 3'b100
  } ufl_brk_t;
endpackage

// ---- verilog/ufl_level_cmp.sv ----
// Threshold compare for one buffer direction.
// Assumes the level input comes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ufl_map.svh"
module ufl_level_cmp (
  input  wire logic [1:0]               code_i,
  input  wire logic                     is_rx_i,
  input  wire logic [`UFL_LVL_W-1:0]    level_i,
  output logic                          hit_o
);
  logic [`UFL_LVL_W-1:0] mark;
  always_comb begin
    mark = '0;
    if (is_rx_i) begin
      unique case (code_i)
        2'b00: mark = 7'h01;
        2'b01: mark = `UFL_DEPTH >> 2;
        2'b10: mark = `UFL_DEPTH >> 1;
        2'b11: mark = `UFL_DEPTH - 7'h02;
      endcase
      hit_o = (level_i >= mark);
    end else begin
      unique case (code_i)
        2'b00: mark = 7'h00;
        2'b01: mark = 7'h02;
        2'b10: mark = `UFL_DEPTH >> 2;
        2'b11: mark = `UFL_DEPTH >> 1;
      endcase
      hit_o = (level_i <= mark);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ufl_ctrl.sv ----
// Buffer control and line control registers with their line-side effects.
// Assumes APB on clk_sys_i; buffer levels and busy come from on-chip logic.
`timescale 1ns/1ps
`default_nettype none
`include "ufl_map.svh"
module ufl_ctrl
  import ufl_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [`UFL_ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  busy_i,
  input  wire logic [`UFL_LVL_W-1:0] rx_level_i,
  input  wire logic [`UFL_LVL_W-1:0] tx_level_i,
  input  wire logic                  auto_flow_i,
  input  wire logic                  ext_dma_i,
  input  wire logic                  loopback_i,
  input  wire logic                  ir_mode_i,
  input  wire logic                  tx_serial_i,
  input  wire logic                  tx_ir_n_i,
  output logic                       serial_out_o,
  output logic                       ir_out_n_o,
  output logic                       loop_break_o,
  output logic                       rts_n_o,
  output logic                       rx_avail_o,
  output logic                       tx_empty_o,
  output logic                       dma_rx_req_n_o,
  output logic                       dma_tx_req_n_o,
  output logic                       tx_buf_clear_o,
  output logic                       rx_buf_clear_o,
  output logic                       buf_enable_o,
  output logic                       divisor_window_bit_o,
  output logic                       check_bit_on_o,
  output logic                       even_parity_o,
  output logic                       stop_long_o,
  output logic                       stop_half_o,
  output logic [1:0]                 char_width_code_o,
  output logic [3:0]                 char_bits_o,
  output logic                       rx_first_stop_only_o
);
  logic [7:0] bc_ff;
  logic [7:0] nxt_bc;
  logic [7:0] lc_ff;
  logic [7:0] nxt_lc;
  logic       txclr_ff;
  logic       nxt_txclr;
  logic       rxclr_ff;
  logic       nxt_rxclr;
  logic [7:0] irdiv_ff;
  logic [7:0] nxt_irdiv;
  logic       irph_ff;
  logic       nxt_irph;
  logic [31:0] rd_ff;
  logic [31:0] nxt_rd;
  logic       rxhold_ff;
  logic       nxt_rxhold;
  logic       txhold_ff;
  logic       nxt_txhold;
  ufl_brk_t   brk_ff;
  ufl_brk_t   nxt_brk;
  logic       wr_acc;
  logic       rd_acc;
  logic       rx_hit;
  logic       tx_hit;
  logic       rx_any;
  logic       tx_none;

  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_acc = psel_i & ~penable_i & ~pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // Register writes and self-clearing reset strobes
  always_comb begin
    nxt_bc = bc_ff;
    nxt_lc = lc_ff;
    nxt_txclr = 1'b0;
    nxt_rxclr = 1'b0;
    if (wr_acc && paddr_i == `UFL_OFS_BUF_CTRL) begin
      nxt_bc = pwdata_i[7:0];
      // Pulse bits are not held; they act once and read back as zero
      nxt_bc[`UFL_BC_TX_RESET] = 1'b0;
      nxt_bc[`UFL_BC_RX_RESET] = 1'b0;
      nxt_txclr = pwdata_i[`UFL_BC_TX_RESET] |
        (pwdata_i[`UFL_BC_BUF_EN] != bc_ff[`UFL_BC_BUF_EN]);
      nxt_rxclr = pwdata_i[`UFL_BC_RX_RESET] |
        (pwdata_i[`UFL_BC_BUF_EN] != bc_ff[`UFL_BC_BUF_EN]);
    end
    if (wr_acc && paddr_i == `UFL_OFS_LINE_CTRL) begin
      // Break is always writable; the framing fields wait for idle
      nxt_lc[`UFL_LC_BREAK] = pwdata_i[`UFL_LC_BREAK];
      if (!busy_i) begin
        nxt_lc = pwdata_i[7:0] & `UFL_LC_WMASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bc_ff <= `UFL_RESET_BC;
      lc_ff <= `UFL_RESET_LC;
      txclr_ff <= 1'b0;
      rxclr_ff <= 1'b0;
    end else begin
      bc_ff <= nxt_bc;
      lc_ff <= nxt_lc;
      txclr_ff <= nxt_txclr;
      rxclr_ff <= nxt_rxclr;
    end
  end

  // Read data; the buffer control offset reads the identification view
  // Capturing in the setup phase keeps read data a flip-flop output
  always_comb begin
    nxt_rd = '0;
    if (rd_acc) begin
      if (paddr_i == `UFL_OFS_IDENT) begin
        nxt_rd[7:6] = {2{bc_ff[`UFL_BC_BUF_EN]}};
        nxt_rd[3:0] = 4'h1;
      end else if (paddr_i == `UFL_OFS_LINE_CTRL) begin
        nxt_rd[7:0] = lc_ff;
      end
    end else begin
      nxt_rd = rd_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_ff <= '0;
    end else begin
      rd_ff <= nxt_rd;
    end
  end
  assign prdata_o = rd_ff;

  ufl_level_cmp u_rx_cmp (
    .code_i  (bc_ff[`UFL_BC_RX_THR_HI:`UFL_BC_RX_THR_LO]),
    .is_rx_i (1'b1),
    .level_i (rx_level_i),
    .hit_o   (rx_hit)
  );
  ufl_level_cmp u_tx_cmp (
    .code_i  (bc_ff[`UFL_BC_TX_THR_HI:`UFL_BC_TX_THR_LO]),
    .is_rx_i (1'b0),
    .level_i (tx_level_i),
    .hit_o   (tx_hit)
  );
  assign rx_any  = (rx_level_i != '0);
  assign tx_none = (tx_level_i == '0);

  // DMA and flow control state, dropped by a buffer reset
  // Threshold hits are registered, so these outputs lag a level by one clock
  // Request-to-send stays released until the receive buffer drains
  always_comb begin
    nxt_rxhold = rxhold_ff;
    nxt_txhold = txhold_ff;
    if (rxclr_ff) begin
      nxt_rxhold = 1'b0;
    end else if (rx_hit) begin
      nxt_rxhold = 1'b1;
    end else if (!rx_any) begin
      nxt_rxhold = 1'b0;
    end
    if (txclr_ff) begin
      nxt_txhold = 1'b0;
    end else if (tx_hit) begin
      nxt_txhold = 1'b1;
    end else begin
      nxt_txhold = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rxhold_ff <= 1'b0;
      txhold_ff <= 1'b0;
    end else begin
      rxhold_ff <= nxt_rxhold;
      txhold_ff <= nxt_txhold;
    end
  end

  assign rx_avail_o = bc_ff[`UFL_BC_BUF_EN] ? rx_hit : rx_any;
  assign tx_empty_o = bc_ff[`UFL_BC_BUF_EN] ? tx_hit : tx_none;
  assign rts_n_o = auto_flow_i & bc_ff[`UFL_BC_BUF_EN] & rxhold_ff;

  // Mode 0 asks for single transfers; mode 1 uses the thresholds with buffers enabled; the extended handshake always uses them
  always_comb begin
    dma_rx_req_n_o = 1'b1;
    dma_tx_req_n_o = 1'b1;
    if (!ext_dma_i) begin
      if (bc_ff[`UFL_BC_DMA_MODE] && bc_ff[`UFL_BC_BUF_EN]) begin
        dma_rx_req_n_o = ~(rxhold_ff & ~rxclr_ff);
        dma_tx_req_n_o = ~(txhold_ff & ~txclr_ff);
      end else begin
        dma_rx_req_n_o = ~(rx_any & ~rxclr_ff);
        dma_tx_req_n_o = ~(tx_none & ~txclr_ff);
      end
    end else begin
      dma_rx_req_n_o = ~(rxhold_ff & ~rxclr_ff);
      dma_tx_req_n_o = ~(txhold_ff & ~txclr_ff);
    end
  end

  // Break path; infrared pulse from a divider enable, no second clock
  // Registered break state adds one clock after a loopback or break change
  always_comb begin
    nxt_brk = UFL_BRK_IDLE;
    if (lc_ff[`UFL_LC_BREAK]) begin
      nxt_brk = loopback_i ? UFL_BRK_LOOP : UFL_BRK_LINE;
    end
    nxt_irdiv = irdiv_ff + 8'h01;
    nxt_irph = irph_ff;
    if (irdiv_ff == `UFL_IR_DIV - 8'h01) begin
      nxt_irdiv = 8'h00;
      nxt_irph = ~irph_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      brk_ff <= UFL_BRK_IDLE;
      irdiv_ff <= 8'h00;
      irph_ff <= 1'b0;
    end else begin
      brk_ff <= nxt_brk;
      irdiv_ff <= nxt_irdiv;
      irph_ff <= nxt_irph;
    end
  end

  always_comb begin
    serial_out_o = tx_serial_i;
    ir_out_n_o = tx_ir_n_i;
    loop_break_o = 1'b0;
    unique case (brk_ff)
      UFL_BRK_IDLE: begin
        serial_out_o = tx_serial_i;
      end
      UFL_BRK_LINE: begin
        serial_out_o = 1'b0;
        if (ir_mode_i) begin
          ir_out_n_o = irph_ff;
        end
      end
      UFL_BRK_LOOP: begin
        loop_break_o = 1'b1;
        ir_out_n_o = 1'b0;
      end
      default: begin
        serial_out_o = tx_serial_i;
      end
    endcase
  end

  assign tx_buf_clear_o = txclr_ff;
  assign rx_buf_clear_o = rxclr_ff;
  assign buf_enable_o = bc_ff[`UFL_BC_BUF_EN];
  assign divisor_window_bit_o = lc_ff[`UFL_LC_DIV_WIN];
  assign even_parity_o = lc_ff[`UFL_LC_EVEN];
  assign check_bit_on_o = lc_ff[`UFL_LC_CHECK_ON];
  assign stop_long_o = lc_ff[`UFL_LC_STOP];
  assign stop_half_o = lc_ff[`UFL_LC_STOP] &
    (lc_ff[`UFL_LC_WIDTH_HI:`UFL_LC_WIDTH_LO] == 2'b00);
  assign char_width_code_o = lc_ff[`UFL_LC_WIDTH_HI:`UFL_LC_WIDTH_LO];
  assign char_bits_o = 4'h5 + {2'b00, char_width_code_o};
  // Only one stop bit is ever sampled on receive
  assign rx_first_stop_only_o = 1'b1;
endmodule
`default_nettype wire

// ---- bench/ufl_ctrl_properties.sv ----
// Assertion checker for the buffer and line control block.
// Assumes it is bound onto ufl_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ufl_ctrl_chk (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        busy_i,
  input wire logic        loopback_i,
  input wire logic        tx_serial_i,
  input wire logic        serial_out_o,
  input wire logic        ir_out_n_o,
  input wire logic        loop_break_o,
  input wire logic        tx_buf_clear_o,
  input wire logic        rx_buf_clear_o,
  input wire logic        buf_enable_o,
  input wire logic        stop_long_o,
  input wire logic        stop_half_o,
  input wire logic [1:0]  char_width_code_o,
  input wire logic [3:0]  char_bits_o,
  input wire logic        rx_first_stop_only_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  a_break_serial_low: assert property (serial_out_o != tx_serial_i |->
    !serial_out_o && !$past(loopback_i)) else $error("serial out wrong");
  a_loop_ir_low: assert property (loopback_i && loop_break_o |->
    !ir_out_n_o) else $error("infrared not low in loop break");
  a_half_stop: assert property (stop_half_o ==
    (stop_long_o && char_width_code_o == 2'h0)) else $error("stop half");
  a_width_bits: assert property (char_bits_o ==
    4'h5 + char_width_code_o) else $error("char bits");
  a_first_stop: assert property (rx_first_stop_only_o)
    else $error("first stop only low");
  a_tx_clear_pulse: assert property (wr && paddr_i == 8'h08 && pwdata_i[2]
    |=> tx_buf_clear_o ##1 !tx_buf_clear_o) else $error("tx clear");
  a_rx_clear_pulse: assert property (wr && paddr_i == 8'h08 && pwdata_i[1]
    |=> rx_buf_clear_o ##1 !rx_buf_clear_o) else $error("rx clear");
  a_enable_clears: assert property ($changed(buf_enable_o) |->
    tx_buf_clear_o && rx_buf_clear_o) else $error("enable no clear");
  a_busy_hold: assert property (wr && busy_i && paddr_i == 8'h0c |=>
    $stable(char_width_code_o) && $stable(stop_long_o)) else $error("busy");
endmodule
bind ufl_ctrl ufl_ctrl_chk u_chk (.clk_sys_i, .rst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .busy_i, .loopback_i, .tx_serial_i,
  .serial_out_o, .ir_out_n_o, .loop_break_o, .tx_buf_clear_o,
  .rx_buf_clear_o, .buf_enable_o, .stop_long_o, .stop_half_o,
  .char_width_code_o, .char_bits_o, .rx_first_stop_only_o);
`default_nettype wire

// ---- bench/ufl_remote.sv ----
// Far-end line device: watches the serial and infrared outputs.
// Assumes both lines are sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module ufl_remote (
  input  wire logic       clk_sys_i,
  input  wire logic       serial_i,
  input  wire logic       ir_n_i,
  output logic      [7:0] ir_edges_o,
  output logic      [7:0] low_run_o
);
  logic ir_q;
  // Infrared line idles high, so the edge memory starts high
  initial {ir_q, ir_edges_o, low_run_o} = {1'b1, 16'h0000};
  // A long spacing run is how a real receiver spots a break
  always @(posedge clk_sys_i) begin
    ir_q <= ir_n_i;
    ir_edges_o <= ir_edges_o + 8'(ir_q != ir_n_i);
    low_run_o <= serial_i ? 8'h00 : low_run_o + 8'h01;
  end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Testbench of the buffer and line control block.
// Assumes design, checker and far-end model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, busy_i;
  logic       auto_flow_i, loopback_i, ir_mode_i, ext_dma_i;
  logic [7:0] paddr_i, ir_edges, low_run, e;
  logic [31:0] pwdata_i, prdata_o;
  logic [6:0] rx_level_i, tx_level_i;
  logic       serial_out_o, ir_out_n_o, loop_break_o, rts_n_o, rx_avail_o;
  logic       tx_empty_o, dma_rx_req_n_o, dma_tx_req_n_o, tx_buf_clear_o;
  logic       rx_buf_clear_o, buf_enable_o, divisor_window_bit_o;
  logic       check_bit_on_o, even_parity_o, stop_long_o, stop_half_o;
  logic [1:0] char_width_code_o;
  logic [3:0] char_bits_o;
  int         checks, n_fail, cyc;
  int         rt[4] = '{1, 16, 32, 62};
  int         tt[4] = '{0, 2, 16, 32};
  ufl_ctrl dut (.clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o(), .pslverr_o(), .busy_i,
    .rx_level_i, .tx_level_i, .auto_flow_i, .ext_dma_i, .loopback_i,
    .ir_mode_i, .tx_serial_i(1'b1), .tx_ir_n_i(1'b1), .serial_out_o,
    .ir_out_n_o, .loop_break_o, .rts_n_o, .rx_avail_o, .tx_empty_o,
    .dma_rx_req_n_o, .dma_tx_req_n_o, .tx_buf_clear_o, .rx_buf_clear_o,
    .buf_enable_o, .divisor_window_bit_o, .check_bit_on_o, .even_parity_o,
    .stop_long_o, .stop_half_o, .char_width_code_o, .char_bits_o,
    .rx_first_stop_only_o());
  ufl_remote u_far (.clk_sys_i, .serial_i(serial_out_o),
    .ir_n_i(ir_out_n_o), .ir_edges_o(ir_edges), .low_run_o(low_run));
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick(1);
    {psel_i, pwrite_i, paddr_i, pwdata_i} = {2'h3, a, d};
    tick(1);
    penable_i = 1'h1;
    tick(1);
    {psel_i, penable_i, pwrite_i} = 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    tick(1);
    {psel_i, pwrite_i, paddr_i} = {2'h2, a};
    tick(1);
    penable_i = 1'h1;
    tick(1);
    {psel_i, penable_i} = 2'h0;
    chk(prdata_o, x);
  endtask
  initial begin
    clk_sys_i = 1'h0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // A hang costs a mismatch rather than an endless run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {psel_i, penable_i, pwrite_i, busy_i, auto_flow_i} = 5'h00;
    {ext_dma_i, loopback_i, ir_mode_i, paddr_i, pwdata_i} = '0;
    {rx_level_i, tx_level_i} = '0;
    rst_i = 1'h1;
    tick(3);
    rst_i = 1'h0;
    rd(8'h0c, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
    rd(8'h20, 32'h0000_0000);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 32'h0000_00df);
    chk(divisor_window_bit_o, 1);
    for (int w = 0; w < 4; w++) begin
      wr(8'h0c, 32'h0000_0004 | 32'(w));
      chk(char_bits_o, 5 + w);
      chk(stop_half_o, w == 0);
    end
    wr(8'h0c, 32'h0000_0018);
    chk({check_bit_on_o, even_parity_o, stop_long_o}, 3'h6);
    wr(8'h0c, 32'h0000_0008);
    chk({check_bit_on_o, even_parity_o}, 2'h2);
    busy_i = 1'h1;
    wr(8'h0c, 32'h0000_0043);
    rd(8'h0c, 32'h0000_0048);
    busy_i = 1'h0;
    tick(40);
    chk(serial_out_o, 0);
    chk(low_run >= 8'h20, 1);
    ir_mode_i = 1'h1;
    e = ir_edges;
    tick(40);
    chk(ir_edges - e >= 8'h02, 1);
    loopback_i = 1'h1;
    tick(1);
    chk({loop_break_o, ir_out_n_o, serial_out_o}, 3'h5);
    tick(2);
    {loopback_i, ir_mode_i} = 2'h0;
    wr(8'h0c, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    chk({buf_enable_o, tx_buf_clear_o, rx_buf_clear_o}, 3'h7);
    wr(8'h08, 32'h0000_0007);
    chk({buf_enable_o, tx_buf_clear_o, rx_buf_clear_o}, 3'h7);
    tick(1);
    chk({tx_buf_clear_o, rx_buf_clear_o}, 2'h0);
    rd(8'h08, 32'h0000_00c1);
    wr(8'h08, 32'h0000_0000);
    chk({buf_enable_o, tx_buf_clear_o, rx_buf_clear_o}, 3'h3);
    auto_flow_i = 1'h1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, 32'h0000_0009 | 32'(c << 6) | 32'(c << 4));
      {rx_level_i, tx_level_i} = {7'(rt[c] - 1), 7'(tt[c] + 1)};
      tick(1);
      chk({rx_avail_o, rts_n_o, dma_rx_req_n_o, tx_empty_o,
        dma_tx_req_n_o}, 5'h05);
      {rx_level_i, tx_level_i} = {7'(rt[c]), 7'(tt[c])};
      tick(1);
      chk({rx_avail_o, rts_n_o, dma_rx_req_n_o, tx_empty_o,
        dma_tx_req_n_o}, 5'h1a);
      rx_level_i = 7'h00;
    end
    wr(8'h08, 32'h0000_00f1);
    {rx_level_i, tx_level_i} = {7'h05, 7'h05};
    #1 chk({dma_rx_req_n_o, dma_tx_req_n_o}, 2'h1);
    tick(1);
    // Extended handshake: threshold requests, dropped by the buffer resets
    ext_dma_i = 1'h1;
    rx_level_i = 7'h3e;
    tick(1);
    chk({dma_rx_req_n_o, dma_tx_req_n_o}, 2'h0);
    wr(8'h08, 32'h0000_00f7);
    chk({dma_rx_req_n_o, dma_tx_req_n_o}, 2'h3);
    tick(1);
    chk({dma_rx_req_n_o, dma_tx_req_n_o}, 2'h3);
    conclude();
  end
endmodule
`default_nettype wire
